//--- core/sarcm_pkg.sv
// shared constants of the converter control block
// assumes a 4 ns core clock that also times the conversion
package sarcm_pkg;
   localparam int RESULT_BITS  = 18;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CONV_MIN_NS  = 500;
   localparam int CONV_MAX_NS  = 710;
   localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int STEP_CYC     = (CONV_MIN_CYC + RESULT_BITS - 1) / RESULT_BITS;
   localparam int FRAME_PLAIN  = RESULT_BITS;
   localparam int FRAME_BUSY   = RESULT_BITS + 1;
   localparam int EDGE_W       = 6;
   localparam logic RST_DRIVE  = 1'b0;
   localparam logic RST_CONN   = 1'b1;
   localparam logic RST_PDOWN  = 1'b1;
   localparam logic RST_CS_N   = 1'b1;
endpackage

//--- core/sarcm_top.sv
// conversion sequencing and serial read-out of a successive-approximation converter
// assumes the host drives the strobe, serial input and serial clock from its own clock
`timescale 1ns/1ps
`default_nettype none
module sarcm_top #(
   parameter logic [3:0] CONV_STEP_CYC = 4'(sarcm_pkg::STEP_CYC)
) (
   input  wire logic                               CLK,
   input  wire logic                               RESET_N,
   input  wire logic                               SCLK,
   input  wire logic                               CONVERSION_START_STROBE,
   input  wire logic                               DIN,
   input  wire logic [sarcm_pkg::RESULT_BITS-1:0]  POSITIVE_ANALOG_INPUT,
   input  wire logic [sarcm_pkg::RESULT_BITS-1:0]  NEGATIVE_ANALOG_INPUT,
   output logic                                    DOUT,
   output logic                                    DOUT_OE_N,
   output logic                                    INPUTS_CONNECTED,
   output logic                                    POWER_DOWN,
   output logic                                    CONVERTING
);
   localparam int RB = sarcm_pkg::RESULT_BITS;
   localparam int EW = sarcm_pkg::EDGE_W;
   localparam logic [4:0] LEN_PLAIN = 5'(sarcm_pkg::FRAME_PLAIN);
   localparam logic [4:0] LEN_BUSY  = 5'(sarcm_pkg::FRAME_BUSY);
   localparam logic [RB-1:0] SIGN_BIT = {1'b1, {(RB-1){1'b0}}};

   typedef enum logic {PH_ACQ, PH_CONV} sarcm_phase_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [EW-1:0] gray;
   } sarcm_link_t;

   typedef struct packed {
      logic          conversion_start_strobe_s1;
      logic          conversion_start_strobe_s2;
      logic          din_s1;
      logic          din_s2;
      logic [RB-1:0] pos_s1;
      logic [RB-1:0] pos_s2;
      logic [RB-1:0] neg_s1;
      logic [RB-1:0] neg_s2;
      logic [EW-1:0] gray_s1;
      logic [EW-1:0] gray_s2;
      logic [EW-1:0] cnt_prev;
      logic          conversion_start_strobe_d;
      logic          cs_n_d;
      sarcm_phase_t  phase;
      logic          daisy;
      logic [3:0]    step;
      logic [4:0]    bit_idx;
      logic [RB-1:0] target;
      logic [RB-1:0] code;
      logic [RB-1:0] result;
      logic [RB:0]   sr;
      logic          drive;
      logic [4:0]    edges;
      logic [4:0]    len;
      logic          inputs_connected;
      logic          power_down;
      logic          converting;
   } sarcm_core_t;

   function automatic logic [EW-1:0] g2b(input logic [EW-1:0] g);
      logic [EW-1:0] b;
      b[EW-1] = g[EW-1];
      for (int i = EW - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic [EW-1:0] b2g(input logic [EW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // difference of the two held inputs, clamped, as offset-binary search target
   function automatic logic [RB-1:0] diff_target(input logic [RB-1:0] p,
                                                 input logic [RB-1:0] m);
      logic signed [RB:0] d;
      logic [RB-1:0]      c;
      d = $signed({1'b0, p}) - $signed({1'b0, m});
      if (d > $signed({2'b00, {(RB-1){1'b1}}}))
      begin
         c = {1'b0, {(RB-1){1'b1}}};
      end
      else if (d < $signed({2'b11, {(RB-1){1'b0}}}))
      begin
         c = SIGN_BIT;
      end
      else
      begin
         c = d[RB-1:0];
      end
      return c ^ SIGN_BIT;
   endfunction

   // serial clock domain: only counts falling edges, so a stopped clock loses nothing
   // the count wraps freely; the core only needs to see that it moved by one
   // gray coding keeps each step a single-bit change for the crossing
   sarcm_link_t lk_reg;
   sarcm_link_t lk_next;

   always_comb
   begin
      lk_next        = lk_reg;
      lk_next.rst_s1 = RESET_N;
      lk_next.rst_s2 = lk_reg.rst_s1;
      if (!lk_reg.rst_s2)
      begin
         lk_next.gray = '0;
      end
      else
      begin
         lk_next.gray = b2g(g2b(lk_reg.gray) + 6'h01);
      end
   end

   always_ff @(negedge SCLK)
   begin
      lk_reg <= lk_next;
   end

   // core clock domain
   sarcm_core_t st_reg;
   sarcm_core_t st_next;

   logic          conv_rise;
   logic          edge_now;
   logic          cs_n;
   logic [RB-1:0] cand;
   logic [RB-1:0] code_f;
   logic [4:0]    edges_inc;

   always_comb
   begin
      st_next           = st_reg;
      st_next.conversion_start_strobe_s1 = CONVERSION_START_STROBE;
      st_next.conversion_start_strobe_s2 = st_reg.conversion_start_strobe_s1;
      st_next.din_s1    = DIN;
      st_next.din_s2    = st_reg.din_s1;
      st_next.pos_s1    = POSITIVE_ANALOG_INPUT;
      st_next.pos_s2    = st_reg.pos_s1;
      st_next.neg_s1    = NEGATIVE_ANALOG_INPUT;
      st_next.neg_s2    = st_reg.neg_s1;
      st_next.gray_s1   = lk_reg.gray;
      st_next.gray_s2   = st_reg.gray_s1;
      st_next.cnt_prev  = g2b(st_reg.gray_s2);
      st_next.conversion_start_strobe_d  = st_reg.conversion_start_strobe_s2;

      // edges come from synchronised copies only; apart from the synchronisers, only the reset pin is read directly
      conv_rise = st_reg.conversion_start_strobe_s2 & ~st_reg.conversion_start_strobe_d;
      edge_now  = g2b(st_reg.gray_s2) != st_reg.cnt_prev;
      // four-wire select is the serial input; three-wire ties it high
      cs_n = st_reg.daisy ? st_reg.conversion_start_strobe_s2 : (st_reg.conversion_start_strobe_s2 & st_reg.din_s2);
      st_next.cs_n_d = cs_n;
      cand      = st_reg.code | (SIGN_BIT >> st_reg.bit_idx);
      code_f    = (cand <= st_reg.target) ? cand : st_reg.code;
      edges_inc = st_reg.edges + 5'h01;

      case (st_reg.phase)
         PH_ACQ:
         begin
            if (conv_rise)
            begin
               st_next.phase            = PH_CONV;
               st_next.daisy            = ~st_reg.din_s2;
               st_next.drive            = 1'b0;
               st_next.target           = diff_target(st_reg.pos_s2, st_reg.neg_s2);
               st_next.code             = '0;
               st_next.bit_idx          = 5'h00;
               st_next.step             = 4'h0;
               st_next.inputs_connected = 1'b0;
               st_next.power_down       = 1'b0;
               st_next.converting       = 1'b1;
            end
            else
            begin
               if (~cs_n & st_reg.cs_n_d & ~st_reg.drive)
               begin
                  st_next.sr    = {st_reg.result, 1'b0};
                  st_next.drive = 1'b1;
                  st_next.edges = 5'h00;
                  st_next.len   = LEN_PLAIN;
               end
               else if (st_reg.drive)
               begin
                  if (edge_now)
                  begin
                     // daisy chain pulls the upstream word in behind ours
                     st_next.sr    = {st_reg.sr[RB-1:0], st_reg.din_s2};
                     st_next.edges = edges_inc;
                  end
                  if (cs_n || (!st_reg.daisy && edge_now && edges_inc == st_reg.len))
                  begin
                     st_next.drive = 1'b0;
                  end
               end
            end
         end
         PH_CONV:
         begin
            // fixed step count keeps the length inside the conversion window
            // one result bit decided per step, most significant bit first
            // a strobe rise is ignored here and simply lost; select is read only on the last step
            if (st_reg.step == CONV_STEP_CYC - 4'h1)
            begin
               st_next.step    = 4'h0;
               st_next.code    = code_f;
               st_next.bit_idx = st_reg.bit_idx + 5'h01;
               if (st_reg.bit_idx == 5'(RB - 1))
               begin
                  st_next.result           = code_f ^ SIGN_BIT;
                  st_next.phase            = PH_ACQ;
                  st_next.inputs_connected = 1'b1;
                  st_next.power_down       = 1'b1;
                  st_next.converting       = 1'b0;
                  if (!cs_n)
                  begin
                     st_next.sr    = {1'b0, code_f ^ SIGN_BIT};
                     st_next.drive = 1'b1;
                     st_next.edges = 5'h00;
                     st_next.len   = LEN_BUSY;
                  end
               end
            end
            else
            begin
               st_next.step = st_reg.step + 4'h1;
            end
         end
         default:
         begin
            st_next.phase = PH_ACQ;
         end
      endcase

      // limitation: analog codes cross bitwise, so they must hold still around the strobe
      // reset clears the sequencer but not what the pins currently show
      if (!RESET_N)
      begin
         st_next                  = '0;
         // synchronisers keep following their pins through reset, so the
         // first edges after release compare against real levels, not zeros
         st_next.conversion_start_strobe_s1        = CONVERSION_START_STROBE;
         st_next.conversion_start_strobe_s2        = st_reg.conversion_start_strobe_s1;
         st_next.conversion_start_strobe_d         = st_reg.conversion_start_strobe_s2;
         st_next.din_s1           = DIN;
         st_next.din_s2           = st_reg.din_s1;
         st_next.pos_s1           = POSITIVE_ANALOG_INPUT;
         st_next.pos_s2           = st_reg.pos_s1;
         st_next.neg_s1           = NEGATIVE_ANALOG_INPUT;
         st_next.neg_s2           = st_reg.neg_s1;
         st_next.gray_s1          = lk_reg.gray;
         st_next.gray_s2          = st_reg.gray_s1;
         st_next.cnt_prev         = g2b(st_reg.gray_s2);
         // select taken as settled at its present level: no false fall at release
         st_next.cs_n_d           = cs_n | sarcm_pkg::RST_CS_N & ~RESET_N & cs_n;
         st_next.phase            = PH_ACQ;
         st_next.drive            = sarcm_pkg::RST_DRIVE;
         st_next.inputs_connected = sarcm_pkg::RST_CONN;
         st_next.power_down       = sarcm_pkg::RST_PDOWN;
      end
   end

   always_ff @(posedge CLK)
   begin
      st_reg <= st_next;
   end

   assign DOUT             = st_reg.sr[RB];
   assign DOUT_OE_N        = ~st_reg.drive;
   assign INPUTS_CONNECTED = st_reg.inputs_connected;
   assign POWER_DOWN       = st_reg.power_down;
   assign CONVERTING       = st_reg.converting;
endmodule
`default_nettype wire

//--- test/sarcm_top_sva.sv
// port assertions for the converter control block
// assumes one core clock domain; bound to sarcm_top
`timescale 1ns/1ps
`default_nettype none
module sarcm_top_sva (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CONVERSION_START_STROBE,
   input wire logic DIN,
   input wire logic DOUT,
   input wire logic DOUT_OE_N,
   input wire logic INPUTS_CONNECTED,
   input wire logic POWER_DOWN,
   input wire logic CONVERTING
);
   int        conv_cnt;
   wire logic sel_hi = CONVERSION_START_STROBE && DIN;
   always_ff @(posedge CLK)
      conv_cnt <= CONVERTING ? conv_cnt + 1 : 0;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   start_release_a: assert property (
      $rose(CONVERTING) |-> $past(CONVERSION_START_STROBE) && DOUT_OE_N)
      else $error("conversion start outputs wrong");
   conv_isolate_a: assert property (
      CONVERTING |-> !INPUTS_CONNECTED && !POWER_DOWN && DOUT_OE_N)
      else $error("inputs or power wrong in conversion");
   acq_power_a: assert property (!CONVERTING |-> POWER_DOWN && INPUTS_CONNECTED)
      else $error("acquisition not powered down");
   conv_length_a: assert property (
      $fell(CONVERTING) |-> conv_cnt >= sarcm_pkg::CONV_MIN_CYC - 1
                            && conv_cnt <= sarcm_pkg::CONV_MAX_CYC)
      else $error("conversion length out of bounds");
   busy_bit_a: assert property (
      $fell(CONVERTING) && !CONVERSION_START_STROBE |-> ##[0:1] (!DOUT_OE_N && !DOUT))
      else $error("busy bit missing");
   no_busy_a: assert property ($fell(CONVERTING) && sel_hi |-> DOUT_OE_N [*2])
      else $error("busy bit without select");
   sel_release_a: assert property (sel_hi [*5] |-> DOUT_OE_N)
      else $error("output driven with select high");
   drive_msb_a: assert property (
      $fell(sel_hi) && !CONVERTING |-> ##[2:5] !DOUT_OE_N)
      else $error("select low did not drive output");
   cover property ($fell(CONVERTING) && !CONVERSION_START_STROBE);
   cover property ($fell(sel_hi) && !CONVERTING);
   cover property ($rose(DOUT_OE_N) && !sel_hi && !CONVERTING);
endmodule
bind sarcm_top sarcm_top_sva chk (.CLK(CLK), .RESET_N(RESET_N), .DIN(DIN), .DOUT(DOUT),
   .CONVERSION_START_STROBE(CONVERSION_START_STROBE), .DOUT_OE_N(DOUT_OE_N),
   .INPUTS_CONNECTED(INPUTS_CONNECTED), .POWER_DOWN(POWER_DOWN), .CONVERTING(CONVERTING));
`default_nettype wire

//--- test/sarcm_host.sv
// host model: strobe, serial input and serial clock; reads the serial output
// assumes a pull-up on the serial output, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module sarcm_host (
   input  wire logic clk,
   input  wire logic dout,
   input  wire logic dout_oe_n,
   output var logic  sclk,
   output var logic  strobe,
   output var logic  din
);
   wire logic line = dout_oe_n ? 1'b1 : dout;
   initial
   begin
      sclk = 1'b1;
      strobe = 1'b1;
      din = 1'b1;
   end
   // select is the serial input only in four-wire operation
   task automatic sel(input logic lvl, input logic four);
      @(posedge clk);
      if (four)
         din <= lvl;
      else
         strobe <= lvl;
      repeat (8) @(posedge clk);
   endtask
   task automatic start(input logic strap, input logic busy, input logic four);
      sel(1'b0, 1'b0);
      din <= strap;
      repeat (8) @(posedge clk);
      strobe <= 1'b1;
      repeat (10) @(posedge clk);
      if (busy)
         sel(1'b0, four);
      // no result is expected before the longest conversion is over
      repeat (sarcm_pkg::CONV_MAX_CYC + 10) @(posedge clk);
   endtask
   // clock stands high between frames; bits sampled after the next fall
   task automatic read(input int n, output logic [18:0] v);
      v = '0;
      for (int i = 0; i < n; i++)
      begin
         #7.5 sclk = 1'b0;
         #6 v = {v[17:0], line};
         #1.5 sclk = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

//--- test/test_sar_adc_conversion_and_mode_select.sv
// self-checking bench: six interface variants, abort and re-read, reset
// assumes the host model drives strobe, serial input and serial clock
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_and_mode_select;
   typedef struct packed {
      logic        strap;
      logic        four;
      logic        busy;
      logic [17:0] pos;
      logic [17:0] neg;
   } sarcm_row_t;
   sarcm_row_t  rows [6] = '{
      '{1'b1, 1'b0, 1'b0, 18'h3FFFF, 18'h00000}, '{1'b1, 1'b0, 1'b1, 18'h00000, 18'h3FFFF},
      '{1'b1, 1'b1, 1'b0, 18'h00005, 18'h00007}, '{1'b1, 1'b1, 1'b1, 18'h12345, 18'h02345},
      '{1'b0, 1'b0, 1'b0, 18'h20000, 18'h1FFFF}, '{1'b0, 1'b0, 1'b1, 18'h2AAAA, 18'h15555}};
   logic        clk;
   logic        rst_n = 1'b0;
   logic [17:0] pos = '0;
   logic [17:0] neg = '0;
   logic [18:0] got;
   logic        sclk, strobe, din, dout, dout_oe_n, in_conn, pdown, conv;
   int          num_errors = 0;
   int          n_compared = 0;
   sarcm_host host (.clk(clk), .dout(dout), .dout_oe_n(dout_oe_n), .sclk(sclk),
      .strobe(strobe), .din(din));
   sarcm_top uut (.CLK(clk), .RESET_N(rst_n), .SCLK(sclk), .CONVERSION_START_STROBE(strobe),
      .DIN(din), .POSITIVE_ANALOG_INPUT(pos), .NEGATIVE_ANALOG_INPUT(neg), .DOUT(dout),
      .DOUT_OE_N(dout_oe_n), .INPUTS_CONNECTED(in_conn), .POWER_DOWN(pdown),
      .CONVERTING(conv));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [17:0] diff(input logic [17:0] p, input logic [17:0] n);
      int d;
      d = int'(p) - int'(n);
      if (d > 32'sh1FFFF)
         d = 32'sh1FFFF;
      if (d < -32'sh20000)
         d = -32'sh20000;
      return 18'(d);
   endfunction
   task automatic check(input logic [18:0] seen, input logic [18:0] want);
      n_compared++;
      if (seen !== want)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // the serial-clock side resets through its own sync, so it needs edges meanwhile
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      host.read(4, got);
      repeat (20) @(posedge clk);
      check({pdown, in_conn, dout_oe_n, conv}, 19'hE);
      rst_n <= 1'b1;
      // two idle serial falls let the serial-side reset sync release before a frame
      host.read(2, got);
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      do_reset();
      foreach (rows[i])
      begin
         pos <= rows[i].pos;
         neg <= rows[i].neg;
         host.start(rows[i].strap, rows[i].busy, rows[i].four);
         if (!rows[i].busy)
            host.sel(1'b0, rows[i].four);
         host.read(rows[i].busy ? 19 : 18, got);
         check(got, {1'b0, diff(rows[i].pos, rows[i].neg)});
         repeat (8) @(posedge clk);
         check(dout_oe_n, rows[i].strap);
         if (rows[i].four)
            host.sel(1'b1, 1'b1);
      end
      // abort a four-wire frame mid-way, then read the kept result again
      pos <= 18'h0F0F0;
      neg <= 18'h00101;
      host.start(1'b1, 1'b0, 1'b1);
      host.sel(1'b0, 1'b1);
      host.read(5, got);
      check(got[4:0], 5'h07);
      host.sel(1'b1, 1'b1);
      check(dout_oe_n, 1'b1);
      host.sel(1'b0, 1'b1);
      host.read(18, got);
      check(got, {1'b0, diff(18'h0F0F0, 18'h00101)});
      do_reset();
      host.start(1'b1, 1'b0, 1'b0);
      host.sel(1'b0, 1'b0);
      host.read(18, got);
      check(got, {1'b0, diff(18'h0F0F0, 18'h00101)});
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
